// ==== verilog/adcr_cfg.svh ====
// Offsets, fixed status bit values, reset values and counts of the ADC register bank
`ifndef ADCR_CFG_SVH
`define ADCR_CFG_SVH
`define ADCR_OFF_ADDR    3'h3
`define ADCR_GAIN_ADDR   3'h4
`define ADCR_OVR_ADDR    3'h5
`define ADCR_OFF_RST     16'h0000
`define ADCR_GAIN_RST    16'hA000
`define ADCR_OVR_RST     16'hCCCC
`define ADCR_GAIN_SHIFT  15
`define ADCR_MOD_LIMIT   3'h4
`define ADCR_ST_B10      1'h0
`define ADCR_ST_B3       1'h1
`endif

// ==== verilog/adcr_pkg.sv ====
// Types shared by the ADC status and correction register bank
package adcr_pkg;
    // Which word the next read returns
    typedef enum logic [2:0] {
        ADCR_RD_NONE = 3'b000,
        ADCR_RD_STAT = 3'b001,
        ADCR_RD_OFF  = 3'b010,
        ADCR_RD_GAIN = 3'b011,
        ADCR_RD_OVR  = 3'b100
    } adcr_rd_sel_t;
    // Status word layout, MSB first
    typedef struct packed {
        logic [1:0] part_id;
        logic [2:0] die_id;
        logic       zero_b10;
        logic       reduced_power_flag;
        logic       overrange;
        logic       coeff_load_verified;
        logic       fir_check_ok;
        logic       custom_fir_active;
        logic       third_stage_bypass;
        logic       one_b3;
        logic [2:0] downsample_ratio_select;
    } adcr_status_t;
    // Register write from the serial decoder
    typedef struct packed {
        logic        en;
        logic [2:0]  addr;
        logic [15:0] data;
    } adcr_wr_t;
endpackage

// ==== verilog/adcr_regs.sv ====
// ADC status word, offset, gain and overrange registers with correction path
`timescale 1ns/1ns
`include "adcr_cfg.svh"
module adcr_regs #(
    parameter logic [1:0] PART_ID = 2'h1,   // Arbitrary value
    parameter logic [2:0] DIE_ID  = 3'h2,   // Arbitrary value
    parameter int         CK_W    = 24
) (
    input  wire logic                   core_clk,
    input  wire logic                   nrst,
    input  wire logic                   ce,
    input  wire adcr_pkg::adcr_wr_t     wr,
    input  wire logic                   rd_en,
    input  wire adcr_pkg::adcr_rd_sel_t rd_sel,
    input  wire logic                   reduced_power_flag,
    input  wire logic                   third_stage_bypass,
    input  wire logic [2:0]             downsample_ratio_select,
    input  wire logic                   dec1_valid,
    input  wire logic [23:0]            dec1_data,
    input  wire logic                   mod_tick,
    input  wire logic                   mod_over,
    input  wire logic                   dl_start,
    input  wire logic                   coeff_valid,
    input  wire logic [CK_W-1:0]        coeff_data,
    input  wire logic                   cksum_valid,
    input  wire logic [CK_W-1:0]        cksum_data,
    input  wire logic                   pass_start,
    input  wire logic                   pass_valid,
    input  wire logic [CK_W-1:0]        pass_data,
    input  wire logic                   pass_done,
    input  wire logic                   smp_valid,
    input  wire logic [23:0]            smp_data,
    output logic                        rd_valid,
    output logic [15:0]                 rd_data,
    output adcr_pkg::adcr_status_t      status,
    output logic [5:0]                  decim_factor,
    output logic                        out_valid,
    output logic [23:0]                 out_data
);
    import adcr_pkg::*;

    // ************************************************
    // Register file
    // ************************************************
    logic [15:0] offset_correction_ff;
    logic [15:0] gain_correction_ff;
    logic [15:0] overrange_threshold_ff;
    wire         wr_off  = wr.en && (wr.addr == `ADCR_OFF_ADDR);
    wire         wr_gain = wr.en && (wr.addr == `ADCR_GAIN_ADDR);
    wire         wr_ovr  = wr.en && (wr.addr == `ADCR_OVR_ADDR);

    // Only three addresses decode; anything else, status included, drops
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            offset_correction_ff   <= `ADCR_OFF_RST;
            gain_correction_ff     <= `ADCR_GAIN_RST;
            overrange_threshold_ff <= `ADCR_OVR_RST;
        end
        else if (ce)
        begin
            if (wr_off)
                offset_correction_ff <= wr.data;
            if (wr_gain)
                gain_correction_ff <= wr.data;
            if (wr_ovr)
                overrange_threshold_ff <= wr.data;
        end
    end

    // ************************************************
    // Overrange detection
    // ************************************************
    // Magnitude scaled so 0x10000 would be full scale; top code saturates
    wire [23:0] dec1_mag = dec1_data[23] ? 24'(-dec1_data) : dec1_data;
    wire [15:0] dec1_scl = dec1_mag[23] ? 16'hFFFF : dec1_mag[22:7];
    wire        thr_hit  = dec1_scl > overrange_threshold_ff;
    logic       thr_hit_ff;
    logic [2:0] mod_cnt_ff;
    logic       mod_hit_ff;
    wire        mod_run  = mod_cnt_ff >= `ADCR_MOD_LIMIT;
    wire [2:0]  nxt_mod_cnt = !mod_over ? 3'h0 :
                              mod_run ? mod_cnt_ff : 3'(mod_cnt_ff + 3'h1);

    // Threshold compare updates per first-stage sample, overload per tick
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            thr_hit_ff <= 1'b0;
            mod_cnt_ff <= 3'h0;
            mod_hit_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (dec1_valid)
                thr_hit_ff <= thr_hit;
            if (mod_tick)
            begin
                mod_cnt_ff <= nxt_mod_cnt;
                mod_hit_ff <= mod_over && mod_run;
            end
        end
    end

    // ************************************************
    // Coefficient checksums
    // ************************************************
    logic [CK_W-1:0] dl_sum_ff;
    logic [CK_W-1:0] dl_ref_ff;
    logic [CK_W-1:0] ps_sum_ff;
    logic            coeff_load_verified_ff;
    logic            flt_ok_ff;
    logic            ufir_ff;
    wire             dl_match = cksum_data == dl_sum_ff;
    wire             ps_match = dl_ref_ff == ps_sum_ff;

    // A new download clears its flag; the checksum word sets it and wins
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            dl_sum_ff <= '0;
            dl_ref_ff <= '0;
            coeff_load_verified_ff  <= 1'b0;
            ufir_ff   <= 1'b0;
        end
        else if (ce)
        begin
            if (dl_start)
            begin
                dl_sum_ff <= '0;
                coeff_load_verified_ff  <= 1'b0;
                ufir_ff   <= 1'b0;
            end
            else if (coeff_valid)
                dl_sum_ff <= dl_sum_ff + coeff_data;
            if (cksum_valid)
            begin
                dl_ref_ff <= cksum_data;
                coeff_load_verified_ff  <= dl_match;
                ufir_ff   <= dl_match;
            end
        end
    end

    // Running check only counts while the custom filter is loaded
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            ps_sum_ff <= '0;
            flt_ok_ff <= 1'b0;
        end
        else if (ce)
        begin
            if (pass_start || !ufir_ff)
                ps_sum_ff <= '0;
            else if (pass_valid)
                ps_sum_ff <= ps_sum_ff + pass_data;
            if (!ufir_ff)
                flt_ok_ff <= 1'b0;
            else if (pass_done)
                flt_ok_ff <= ps_match;
        end
    end

    // ************************************************
    // Gain then offset correction
    // ************************************************
    logic              g_vld_ff;
    logic signed [40:0] g_prod_ff;
    wire  signed [40:0] g_prod = 41'($signed(smp_data)) * 41'($signed({1'b0, gain_correction_ff}));
    wire  signed [25:0] g_scl  = 26'(g_prod_ff >>> `ADCR_GAIN_SHIFT);
    // Offset LSB equals one 24-bit code: 0x7FFF is about 2^15 of 2^23
    wire  signed [25:0] o_sum  = g_scl + 26'($signed(offset_correction_ff));
    wire  [23:0]        o_sat  = (o_sum > 26'sh7FFFFF) ? 24'h7FFFFF :
                                 (o_sum < -26'sh800000) ? 24'h800000 : o_sum[23:0];

    // Two stages so the offset only ever sees the gain-scaled value
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            g_vld_ff  <= 1'b0;
            g_prod_ff <= '0;
            out_valid <= 1'b0;
            out_data  <= 24'h000000;
        end
        else if (ce)
        begin
            g_vld_ff  <= smp_valid;
            out_valid <= g_vld_ff;
            if (smp_valid)
                g_prod_ff <= g_prod;
            if (g_vld_ff)
                out_data <= o_sat;
        end
    end

    // ************************************************
    // Status word and read port
    // ************************************************
    adcr_status_t nxt_status;
    assign nxt_status = '{
        part_id:                 PART_ID,
        die_id:                  DIE_ID,
        zero_b10:                `ADCR_ST_B10,
        reduced_power_flag:      reduced_power_flag,
        overrange:               thr_hit_ff || mod_hit_ff,
        coeff_load_verified:     coeff_load_verified_ff,
        fir_check_ok:            flt_ok_ff,
        custom_fir_active:       ufir_ff,
        third_stage_bypass:      third_stage_bypass,
        one_b3:                  `ADCR_ST_B3,
        downsample_ratio_select: downsample_ratio_select
    };
    wire [5:0] nxt_decim = (downsample_ratio_select == 3'h3) ? 6'h08 :
                           (downsample_ratio_select == 3'h4) ? 6'h10 :
                           (downsample_ratio_select == 3'h5) ? 6'h20 : 6'h04;
    // Read-status choice arrives from the control word the host set first
    wire [15:0] nxt_rd = (rd_sel == ADCR_RD_STAT) ? nxt_status :
                         (rd_sel == ADCR_RD_OFF)  ? offset_correction_ff :
                         (rd_sel == ADCR_RD_GAIN) ? gain_correction_ff :
                         (rd_sel == ADCR_RD_OVR)  ? overrange_threshold_ff : 16'h0000;

    // Outputs registered; status lags its sources by one cycle
    always_ff @(posedge core_clk)
    begin
        if (!nrst)
        begin
            status       <= '0;
            decim_factor <= 6'h04;
            rd_valid     <= 1'b0;
            rd_data      <= 16'h0000;
        end
        else if (ce)
        begin
            status       <= nxt_status;
            decim_factor <= nxt_decim;
            rd_valid     <= rd_en;
            if (rd_en)
                rd_data <= nxt_rd;
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!nrst);

    property p_part_fixed;
        ce ##1 ce |-> status[15:11] == {PART_ID, DIE_ID};
    endproperty
    a_part_fixed: assert property (p_part_fixed) else $error("id fields wrong");

    property p_fixed_bits;
        ce ##1 ce |-> !status.zero_b10 && status.one_b3;
    endproperty
    a_fixed_bits: assert property (p_fixed_bits) else $error("fixed bits wrong");

    property p_reduced_power_flag;
        ce |=> status.reduced_power_flag == $past(reduced_power_flag);
    endproperty
    a_reduced_power_flag: assert property (p_reduced_power_flag) else $error("low power bit stale");

    property p_ovr_thr;
        ce && dec1_valid && thr_hit ##1 ce |=> status.overrange;
    endproperty
    a_ovr_thr: assert property (p_ovr_thr) else $error("overrange missed");

    property p_mod5;
        (ce && mod_tick && mod_over) [*5] ##1 ce |=> status.overrange;
    endproperty
    a_mod5: assert property (p_mod5) else $error("modulator overload missed");

    property p_dl;
        ce && cksum_valid && !dl_start ##1 ce |=>
            status.coeff_load_verified == $past(cksum_data == dl_sum_ff, 2);
    endproperty
    a_dl: assert property (p_dl) else $error("download flag wrong");

    property p_dec;
        ce |=> decim_factor == (($past(downsample_ratio_select) < 3'h3 ||
                                 $past(downsample_ratio_select) > 3'h5) ? 6'h04 :
               6'(6'h01 << $past(downsample_ratio_select)));
    endproperty
    a_dec: assert property (p_dec) else $error("decimation decode wrong");

    property p_gain_rst;
        $rose(nrst) |-> gain_correction_ff == `ADCR_GAIN_RST && overrange_threshold_ff == `ADCR_OVR_RST;
    endproperty
    a_gain_rst: assert property (@(posedge core_clk) p_gain_rst) else $error("reset values wrong");

    property p_off_rd;
        ce && rd_en && rd_sel == ADCR_RD_OFF |=> rd_valid && rd_data == $past(offset_correction_ff);
    endproperty
    a_off_rd: assert property (p_off_rd) else $error("offset readback wrong");

    property p_byp;
        ce |=> status.third_stage_bypass == $past(third_stage_bypass);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass bit stale");

    property p_dec_mirror;
        ce |=> status.downsample_ratio_select == $past(downsample_ratio_select);
    endproperty
    a_dec_mirror: assert property (p_dec_mirror) else $error("decimation bits stale");

    property p_ufir_clr;
        ce && dl_start && !cksum_valid ##1 ce |=> !status.custom_fir_active;
    endproperty
    a_ufir_clr: assert property (p_ufir_clr) else $error("custom filter flag not cleared");

    property p_flt;
        ce && pass_done && ufir_ff ##1 ce |=> status.fir_check_ok == $past(dl_ref_ff == ps_sum_ff, 2);
    endproperty
    a_flt: assert property (p_flt) else $error("filter check flag wrong");
endmodule // adcr_regs

// ==== tb/adcr_host.sv ====
// Host controller model: register writes and selected reads
`timescale 1ns/1ns
module adcr_host (
    input  wire logic              core_clk,
    output adcr_pkg::adcr_wr_t     wr,
    output adcr_pkg::adcr_rd_sel_t rd_sel,
    output logic                   rd_en,
    input  wire logic              rd_valid,
    input  wire logic [15:0]       rd_data
);
    import adcr_pkg::*;
    // Idle bus at time zero
    initial
    begin
        wr = '0;
        rd_en = 1'b0;
        rd_sel = ADCR_RD_NONE;
    end
    // One write pulse; data turned over once released
    task automatic wr_reg(input logic [2:0] a, input logic [15:0] d);
        @(negedge core_clk);
        wr = '{1'b1, a, d};
        @(negedge core_clk);
        wr.en = 1'b0;
        wr.data = ~d;
    endtask
    // Select the word first, then read it back
    task automatic rd_reg(input adcr_rd_sel_t s, output logic [15:0] q);
        int n;
        @(negedge core_clk);
        rd_sel = s;
        rd_en = 1'b1;
        @(negedge core_clk);
        rd_en = 1'b0;
        n = 0;
        while (rd_valid !== 1'b1 && n < 4)
        begin
            @(negedge core_clk);
            n++;
        end
        q = (rd_valid === 1'b1) ? rd_data : 16'hXXXX;
        rd_sel = ADCR_RD_NONE;
    endtask
endmodule // adcr_host

// ==== tb/adc_status_and_correction_regs_test.sv ====
// Self-checking bench for the ADC status and correction register bank
`timescale 1ns/1ns
module adc_status_and_correction_regs_test;
    import adcr_pkg::*;
    localparam logic [1:0] PART = 2'h3;   // Arbitrary value
    localparam logic [2:0] DIE  = 3'h5;   // Arbitrary value
    logic          core_clk = 1'b0, nrst = 1'b0, ce = 1'b1;
    logic          reduced_power_flag = 1'b0, third_stage_bypass = 1'b0;
    logic [2:0]    downsample_ratio_select = 3'h0;
    logic          dec1_valid = 1'b0, mod_tick = 1'b0, mod_over = 1'b0, dl_start = 1'b0;
    logic          coeff_valid = 1'b0, cksum_valid = 1'b0, pass_start = 1'b0, pass_valid = 1'b0;
    logic          pass_done = 1'b0, smp_valid = 1'b0;
    logic [23:0]   dec1_data = '0, coeff_data = '0, cksum_data = '0, pass_data = '0;
    logic [23:0]   smp_data = '0, nodata = '0, out_data;
    adcr_wr_t      wr;
    adcr_rd_sel_t  rd_sel;
    adcr_status_t  status;
    logic          rd_en, rd_valid, out_valid;
    logic [15:0]   rd_data;
    logic [5:0]    decim_factor;
    int            failures = 0, check_count = 0, cyc = 0;
    adcr_regs #(.PART_ID(PART), .DIE_ID(DIE)) DUT (.core_clk, .nrst, .ce, .wr, .rd_en, .rd_sel,
        .reduced_power_flag, .third_stage_bypass, .downsample_ratio_select, .dec1_valid, .dec1_data,
        .mod_tick, .mod_over, .dl_start, .coeff_valid, .coeff_data, .cksum_valid, .cksum_data,
        .pass_start, .pass_valid, .pass_data, .pass_done, .smp_valid, .smp_data, .rd_valid, .rd_data,
        .status, .decim_factor, .out_valid, .out_data);
    adcr_host host (.core_clk, .wr, .rd_sel, .rd_en, .rd_valid, .rd_data);
    // 125 MHz clock
    always #4 core_clk = ~core_clk;
    // Hang guard, far above the expected few hundred cycles
    always @(posedge core_clk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            failures++;
            tally_and_finish;
        end
    end
    // ************
    // Helpers
    // ************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(negedge core_clk);
    endtask
    // One-cycle strobe; data word inverted once released
    task automatic strobe(ref logic v, ref logic [23:0] dv, input logic [23:0] d);
        @(negedge core_clk);
        v = 1'b1;
        dv = d;
        @(negedge core_clk);
        v = 1'b0;
        dv = ~d;
    endtask
    task automatic rd_chk(input adcr_rd_sel_t s, input logic [15:0] e);
        logic [15:0] q;
        host.rd_reg(s, q);
        chk(q, e);
    endtask
    function automatic logic [15:0] exp_st(input logic ovr, input logic dl, input logic fk, input logic uf);
        return {PART, DIE, 1'b0, reduced_power_flag, ovr, dl, fk, uf, third_stage_bypass, 1'b1,
                downsample_ratio_select};
    endfunction
    // ************
    // Scenarios
    // ************
    task t_reset;
        rd_chk(ADCR_RD_OFF, 16'h0000);
        rd_chk(ADCR_RD_GAIN, 16'hA000);
        rd_chk(ADCR_RD_OVR, 16'hCCCC);
        rd_chk(ADCR_RD_STAT, exp_st(0, 0, 0, 0));
    endtask
    // Status has no address, so writes there must vanish
    task t_regs;
        host.wr_reg(3'h3, 16'h5A5A);
        host.wr_reg(3'h4, 16'h1234);
        host.wr_reg(3'h5, 16'hFEDC);
        host.wr_reg(3'h0, 16'hFFFF);
        host.wr_reg(3'h7, 16'hFFFF);
        // Clock enable low must drop a write outright
        ce = 1'b0;
        host.wr_reg(3'h3, 16'hDEAD);
        ce = 1'b1;
        rd_chk(ADCR_RD_OFF, 16'h5A5A);
        rd_chk(ADCR_RD_GAIN, 16'h1234);
        rd_chk(ADCR_RD_OVR, 16'hFEDC);
        rd_chk(ADCR_RD_STAT, exp_st(0, 0, 0, 0));
    endtask
    task t_mirror;
        for (int i = 0; i < 8; i++)
        begin
            @(negedge core_clk);
            downsample_ratio_select = 3'(i);
            reduced_power_flag = i[0];
            third_stage_bypass = i[1];
            tick(3);
            chk(status, exp_st(0, 0, 0, 0));
            chk(decim_factor, (i < 3 || i > 5) ? 4 : (4 << (i - 2)));
        end
    endtask
    // Offset-before-gain would give 0x1414 in the third case; the last saturates
    task automatic t_corr;
        logic [15:0] g[5] = '{16'h8000, 16'h8000, 16'hA000, 16'hA000, 16'hFFFF};
        logic [15:0] o[5] = '{16'h7FFF, 16'h8000, 16'h0010, 16'hFFF0, 16'h7FFF};
        logic [23:0] d[5] = '{24'h000123, 24'h000123, 24'h001000, 24'hFFF000, 24'h7FFFFF};
        logic [23:0] e[5] = '{24'h008122, 24'hFF8123, 24'h001410, 24'hFFEBF0, 24'h7FFFFF};
        int n;
        for (int i = 0; i < 5; i++)
        begin
            host.wr_reg(3'h4, g[i]);
            host.wr_reg(3'h3, o[i]);
            strobe(smp_valid, smp_data, d[i]);
            n = 0;
            while (out_valid !== 1'b1 && n < 4)
            begin
                @(negedge core_clk);
                n++;
            end
            chk({out_valid, out_data}, {1'b1, e[i]});
        end
    endtask
    task automatic t_ovr;
        logic [23:0] d[4] = '{24'h008100, 24'h008000, 24'hFF7E00, 24'h000000};
        host.wr_reg(3'h5, 16'h0100);
        for (int i = 0; i < 4; i++)
        begin
            strobe(dec1_valid, dec1_data, d[i]);
            tick(2);
            chk(status, exp_st(~i[0], 0, 0, 0));
        end
        // Five overloaded ticks in a row, then one clean tick
        for (int k = 1; k <= 6; k++)
        begin
            mod_over = (k < 6);
            strobe(mod_tick, nodata, 24'h0);
            tick(2);
            chk(status, exp_st(k == 5, 0, 0, 0));
        end
        // Five overloaded samples on consecutive clocks, then a clean one
        @(negedge core_clk);
        mod_over = 1'b1;
        mod_tick = 1'b1;
        tick(5);
        mod_tick = 1'b0;
        tick(2);
        chk(status, exp_st(1, 0, 0, 0));
        mod_over = 1'b0;
        strobe(mod_tick, nodata, 24'h0);
        tick(2);
        chk(status, exp_st(0, 0, 0, 0));
    endtask
    task automatic t_dl;
        logic [23:0] w[3] = '{24'h000100, 24'h000200, 24'hFFFFFF};
        for (int r = 0; r < 2; r++)
        begin
            strobe(dl_start, nodata, 24'h0);
            foreach (w[i]) strobe(coeff_valid, coeff_data, w[i]);
            strobe(cksum_valid, cksum_data, 24'h0002FF - 24'(r));
            tick(2);
            chk(status, exp_st(0, !r, 0, !r));
            strobe(pass_start, nodata, 24'h0);
            foreach (w[i]) strobe(pass_valid, pass_data, w[i]);
            strobe(pass_done, nodata, 24'h0);
            tick(2);
            chk(status, exp_st(0, !r, !r, !r));
        end
    endtask
    task tally_and_finish;
        $display("comparisons %0d, mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    // Reset for two cycles, then run every scenario
    initial
    begin
        tick(2);
        nrst = 1'b1;
        tick(2);
        t_reset;
        t_regs;
        t_mirror;
        t_corr;
        t_ovr;
        t_dl;
        tally_and_finish;
    end
endmodule // adc_status_and_correction_regs_test
